// [mdm_clock_output_pin.sv]
// clock output divider, half period in core cycles
`timescale 1ns/1ps
module mdm_clock_output_pin (
    input wire logic clk_i, // core clock
    input wire logic nrst_i, // async reset, low
    input wire logic en_i, // run the divider
    input wire logic [8:0] half_i, // half period cycles
    output logic pin_o // divided clock
);
    import mdm_pkg::*;
    mdm_clock_output_pin_st_t st_reg;
    mdm_clock_output_pin_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (!en_i) begin
            st_next = '0;
        end else if (st_reg.cnt + 9'h001 >= half_i) begin
            st_next.cnt = 9'h000;
            st_next.pin = !st_reg.pin;
        end else begin
            st_next.cnt = st_reg.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pin_o = st_reg.pin;
endmodule : mdm_clock_output_pin

// [mdm_host.sv]
// serial host model: drives chip enable, clock and data in mode 0
`timescale 1ns/1ps
module mdm_host (
    input wire logic clk_i, // core clock
    input wire logic miso_i, // resolved serial data in
    output mdm_pkg::mdm_pins_t pins_o // serial pins out
);
    import mdm_pkg::*;
    initial pins_o = '{ce_n: 1'b1, sck: 1'b0, mosi: 1'b0};
    ////////////////////////////////////////////////////////////////////////
    // header plus one word, 8 core cycles per bit keeps sck near 6 MHz
    task automatic txn(input logic [7:0] hdr, input logic [15:0] wd,
                       output logic [15:0] rd);
        logic [23:0] sh;
        sh = {hdr, wd};
        rd = 16'h0000;
        pins_o.ce_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            pins_o.mosi <= sh[i];
            repeat (4) @(posedge clk_i);
            pins_o.sck <= 1'b1;
            if (i < 16) rd = {rd[14:0], miso_i};
            repeat (4) @(posedge clk_i);
            pins_o.sck <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        pins_o.ce_n <= 1'b1;
        pins_o.mosi <= ~pins_o.mosi;
        // two more edges so registered pin outputs have settled
        repeat (2) @(posedge clk_i);
    endtask : txn
endmodule : mdm_host

// [mdm_pkg.sv]
// types shared by the modem port files
package mdm_pkg;
    typedef enum logic [8:0] {
        MDM_OFF = 9'h001,
        MDM_WAKE = 9'h002,
        MDM_IDLE = 9'h004,
        MDM_HIB = 9'h008,
        MDM_DOZE = 9'h010,
        MDM_RXW = 9'h020,
        MDM_RX = 9'h040,
        MDM_TXW = 9'h080,
        MDM_TX = 9'h100
    } mdm_mode_t;
    typedef struct packed {
        logic ce_n;
        logic sck;
        logic mosi;
    } mdm_pins_t;
    typedef struct packed {
        logic hdr;
        logic [7:0] hdr_byte;
        logic wr;
        logic [5:0] waddr;
        logic [15:0] wdata;
        logic rd_phase;
        logic miso;
    } mdm_spi_ev_t;
    typedef struct packed {
        logic sck_q;
        logic [3:0] bit_cnt;
        logic hdr_done;
        logic rd;
        logic [5:0] addr;
        logic [15:0] in_sr;
        logic [15:0] out_sr;
        mdm_spi_ev_t ev;
    } mdm_spi_st_t;
    typedef struct packed {
        logic [8:0] cnt;
        logic pin;
    } mdm_clock_output_pin_st_t;
    typedef struct packed {
        mdm_mode_t mode;
        logic [19:0] cnt;
        logic [19:0] dtmr;
        logic [63:0][15:0] mem;
        logic [19:0] match;
        logic [15:0] xcnt;
        logic [7:0] last_hdr;
        logic miso;
        logic miso_oe;
        logic clock_output_pin_oe;
        logic rx_on;
        logic tx_on;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mdm_top_st_t;
endpackage : mdm_pkg

// [mdm_regs.svh]
// offsets, field positions, reset values and timing for the modem port
`ifndef MDM_REGS_SVH
`define MDM_REGS_SVH
`define MDM_CLK_MHZ 50
`define MDM_T_OFF_US 10000
`define MDM_T_HIB_US 7000
`define MDM_T_DOZE_US 300
`define MDM_T_RXTX_US 144
`define MDM_CYC(us) ((us) * `MDM_CLK_MHZ)
`define MDM_R_MODE 6'h01
`define MDM_B_HIB 0
`define MDM_B_DOZE 1
`define MDM_B_TMR_EN 2
`define MDM_B_TX_SEL 3
`define MDM_R_CTL 6'h07
`define MDM_B_CLOCK_OUTPUT_PIN_DOZE 9
`define MDM_B_FLOAT 11
`define MDM_R_CLOCK_OUTPUT_PIN 6'h0A
`define MDM_CLOCK_OUTPUT_PIN_LF_SEL 3'h4
`define MDM_MEM_RST (1024'h0800 << (7 * 16))
`define MDM_AX_STATUS 8'h00
`define MDM_AX_MATCH 8'h04
`define MDM_AX_COUNT 8'h08
`define MDM_RESP_OK 2'h0
`define MDM_RESP_ERR 2'h2
`endif

// [mdm_spi.sv]
// serial command slave: header, payload words, read shift-out
`timescale 1ns/1ps
`include "mdm_regs.svh"
module mdm_spi (
    input wire logic clk_i, // core clock
    input wire logic nrst_i, // async reset, low
    input wire logic en_i, // port usable
    input wire mdm_pkg::mdm_pins_t pins_i, // host pins
    input wire logic [15:0] rd_data_i, // word at addr_o
    output logic [5:0] addr_o, // current word address
    output mdm_pkg::mdm_spi_ev_t ev_o // events and miso
);
    import mdm_pkg::*;
    mdm_spi_st_t st_reg;
    mdm_spi_st_t st_next;
    logic rise;
    logic fall;

    // sck sampled at core rate, host keeps it slow
    assign rise = pins_i.sck && !st_reg.sck_q;
    assign fall = !pins_i.sck && st_reg.sck_q;

    always_comb begin
        st_next = st_reg;
        st_next.sck_q = pins_i.sck;
        st_next.ev.hdr = 1'b0;
        st_next.ev.wr = 1'b0;
        if (!en_i || pins_i.ce_n) begin
            st_next.bit_cnt = 4'h0;
            st_next.hdr_done = 1'b0;
            st_next.rd = 1'b0;
            st_next.ev.miso = 1'b0;
        end else if (rise) begin
            st_next.in_sr = {st_reg.in_sr[14:0], pins_i.mosi};
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            if (!st_reg.hdr_done) begin
                if (st_reg.bit_cnt == 4'h7) begin
                    st_next.hdr_done = 1'b1;
                    st_next.bit_cnt = 4'h0;
                    st_next.rd = st_reg.in_sr[6];
                    st_next.addr = {st_reg.in_sr[4:0], pins_i.mosi};
                    st_next.ev.hdr = 1'b1;
                    st_next.ev.hdr_byte = st_next.in_sr[7:0];
                end
            end else if (st_reg.bit_cnt == 4'hF) begin
                st_next.addr = st_reg.addr + 6'h01;
                st_next.ev.waddr = st_reg.addr;
                st_next.ev.wdata = st_next.in_sr;
                st_next.ev.wr = !st_reg.rd;
            end
        end else if (fall && st_reg.hdr_done && st_reg.rd) begin
            if (st_reg.bit_cnt == 4'h0) begin
                st_next.ev.miso = rd_data_i[15];
                st_next.out_sr = {rd_data_i[14:0], 1'b0};
            end else begin
                st_next.ev.miso = st_reg.out_sr[15];
                st_next.out_sr = {st_reg.out_sr[14:0], 1'b0};
            end
        end
        st_next.ev.rd_phase = st_next.hdr_done && st_next.rd;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign addr_o = st_reg.addr;
    assign ev_o = st_reg.ev;
endmodule : mdm_spi

// [mdm_top.sv]
// modem command port top: power modes, word store, register bus
//
// How it works
// - reset release moves Off to Idle
// - serial port works in Idle
// - host commands Hibernate and Doze serially
// - Off tri-states miso and clock output; 10 ms to Idle
// - Hibernate: port dead, attention wakes, 7 ms
// - Doze clock output only if enabled, slow
// - Doze to Idle: 300 us plus clkout period
// - Doze wakes on attention or timer match
// - Receive or Transmit entered after 144 us
// - slave only, eight-bit bursts
// - chip enable frames three or more bursts
// - sample rising, change falling, clock idles low
// - eight bits per burst, msb first
// - static shifter, core clock moves words
// - transaction starts when chip enable falls
// - first burst is address and direction header
// - payload one direction only
// - payload at least two bytes
// - reference is fixed, no divider
// - idle miso floats unless float bit cleared
`timescale 1ns/1ps
`include "mdm_regs.svh"
module mdm_top #(
    parameter int T_OFF_CYC = `MDM_CYC(`MDM_T_OFF_US),
    parameter int T_HIB_CYC = `MDM_CYC(`MDM_T_HIB_US),
    parameter int T_DOZE_CYC = `MDM_CYC(`MDM_T_DOZE_US),
    parameter int T_RXTX_CYC = `MDM_CYC(`MDM_T_RXTX_US)
) (
    input wire logic clk_i, // core clock 50 MHz
    input wire logic nrst_i, // async reset, low
    input wire logic modem_rst_n_i, // modem reset pin, low
    input wire mdm_pkg::mdm_pins_t pins_i, // serial pins in
    input wire logic attention_wake_i, // wake request
    input wire logic radio_operation_enable_i, // start rx or tx
    output logic miso_o, // serial data out
    output logic miso_oe_o, // miso driven
    output logic clock_output_pin_o, // divided clock
    output logic clock_output_oe_o, // clock pin driven
    output logic rx_on_o, // receiving
    output logic tx_on_o, // transmitting
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // response valid
    input wire logic s_axi_bready, // response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready // read ready
);
    import mdm_pkg::*;

    localparam mdm_top_st_t ST_RST = '{
        mode: MDM_OFF,
        mem: `MDM_MEM_RST,
        default: '0
    };

    mdm_top_st_t st_reg;
    mdm_top_st_t st_next;
    mdm_spi_ev_t spi_ev;
    logic [5:0] spi_addr;
    logic spi_en;
    logic clock_output_pin_en;
    logic [8:0] half;
    logic [15:0] ctl;
    logic [15:0] mcmd;

    ////////////////////////////////////////////////////////////////////////
    // clock output period: 2 << sel core cycles per half period
    function automatic logic [8:0] clock_output_pin_half(input logic [2:0] sel);
        clock_output_pin_half = 9'h002 << sel;
    endfunction : clock_output_pin_half

    assign ctl = st_reg.mem[`MDM_R_CTL];
    assign mcmd = st_reg.mem[`MDM_R_MODE];
    assign half = clock_output_pin_half(st_reg.mem[`MDM_R_CLOCK_OUTPUT_PIN][2:0]);

    ////////////////////////////////////////////////////////////////////////
    // serial port alive only in awake modes
    assign spi_en = st_reg.mode inside
        {MDM_IDLE, MDM_RXW, MDM_RX, MDM_TXW, MDM_TX};

    mdm_spi u_spi (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(spi_en),
        .pins_i(pins_i),
        .rd_data_i(st_reg.mem[spi_addr]),
        .addr_o(spi_addr),
        .ev_o(spi_ev)
    );

    // doze keeps the clock only when enabled and slow enough
    assign clock_output_pin_en = (st_reg.mode inside
        {MDM_IDLE, MDM_RXW, MDM_RX, MDM_TXW, MDM_TX}) ||
        (st_reg.mode == MDM_DOZE && ctl[`MDM_B_CLOCK_OUTPUT_PIN_DOZE] &&
        st_reg.mem[`MDM_R_CLOCK_OUTPUT_PIN][2:0] >= `MDM_CLOCK_OUTPUT_PIN_LF_SEL);

    mdm_clock_output_pin u_clock_output_pin (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(clock_output_pin_en),
        .half_i(half),
        .pin_o(clock_output_pin_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;
        // words move into the store on the core clock
        if (spi_ev.wr) begin
            st_next.mem[spi_ev.waddr] = spi_ev.wdata;
        end
        if (spi_ev.hdr) begin
            st_next.last_hdr = spi_ev.hdr_byte;
            st_next.xcnt = st_reg.xcnt + 16'h0001;
        end
        case (st_reg.mode)
            MDM_OFF: begin
                if (modem_rst_n_i) begin
                    st_next.mode = MDM_WAKE;
                    st_next.cnt = 20'(T_OFF_CYC);
                end
            end
            MDM_WAKE: begin
                if (st_reg.cnt <= 20'h00001) begin
                    st_next.mode = MDM_IDLE;
                end else begin
                    st_next.cnt = st_reg.cnt - 20'h00001;
                end
            end
            MDM_IDLE: begin
                if (spi_ev.wr && spi_ev.waddr == `MDM_R_MODE &&
                    spi_ev.wdata[`MDM_B_HIB]) begin
                    st_next.mode = MDM_HIB;
                end else if (spi_ev.wr && spi_ev.waddr == `MDM_R_MODE &&
                    spi_ev.wdata[`MDM_B_DOZE]) begin
                    st_next.mode = MDM_DOZE;
                    st_next.dtmr = 20'h00000;
                end else if (radio_operation_enable_i) begin
                    st_next.cnt = 20'(T_RXTX_CYC);
                    st_next.mode = mcmd[`MDM_B_TX_SEL] ? MDM_TXW : MDM_RXW;
                end
            end
            MDM_HIB: begin
                if (attention_wake_i) begin
                    st_next.mode = MDM_WAKE;
                    st_next.cnt = 20'(T_HIB_CYC);
                end
            end
            MDM_DOZE: begin
                st_next.dtmr = st_reg.dtmr + 20'h00001;
                if (attention_wake_i || (mcmd[`MDM_B_TMR_EN] &&
                    st_reg.dtmr == st_reg.match)) begin
                    st_next.mode = MDM_WAKE;
                    st_next.cnt = 20'(T_DOZE_CYC) +
                        {10'h000, half, 1'b0};
                end
            end
            MDM_RXW, MDM_TXW: begin
                if (!radio_operation_enable_i) begin
                    st_next.mode = MDM_IDLE;
                end else if (st_reg.cnt <= 20'h00001) begin
                    st_next.mode = st_reg.mode == MDM_RXW ? MDM_RX : MDM_TX;
                end else begin
                    st_next.cnt = st_reg.cnt - 20'h00001;
                end
            end
            MDM_RX, MDM_TX: begin
                if (!radio_operation_enable_i) begin
                    st_next.mode = MDM_IDLE;
                end
            end
            default: begin
                st_next.mode = MDM_OFF;
            end
        endcase
        if (!modem_rst_n_i) begin
            st_next.mode = MDM_OFF;
        end

        // pin drivers; off floats miso and the clock output, rx_on and tx_on stay driven
        st_next.clock_output_pin_oe = st_reg.mode != MDM_OFF;
        st_next.rx_on = st_reg.mode == MDM_RX;
        st_next.tx_on = st_reg.mode == MDM_TX;
        st_next.miso = spi_ev.miso;
        if (st_reg.mode == MDM_OFF) begin
            st_next.miso_oe = 1'b0;
        end else if (pins_i.ce_n) begin
            st_next.miso_oe = !ctl[`MDM_B_FLOAT];
            st_next.miso = 1'b0;
        end else begin
            st_next.miso_oe = spi_ev.rd_phase;
        end

        ////////////////////////////////////////////////////////////////////
        // register bus: write side
        st_next.awready = s_axi_awvalid && !st_reg.aw_have &&
            !st_reg.awready && !st_reg.bvalid;
        st_next.wready = s_axi_wvalid && !st_reg.w_have &&
            !st_reg.wready && !st_reg.bvalid;
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_have = 1'b1;
            st_next.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_have = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (st_reg.aw_have && st_reg.w_have) begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `MDM_RESP_ERR;
            if ({2'b00, st_reg.waddr[7:2]} == (`MDM_AX_MATCH >> 2)) begin
                st_next.bresp = `MDM_RESP_OK;
                for (int b = 0; b < 3; b++) begin
                    if (st_reg.wstrb[b]) begin
                        if (b == 2) begin
                            st_next.match[19:16] = st_reg.wdata[19:16];
                        end else begin
                            st_next.match[b*8 +: 8] =
                                st_reg.wdata[b*8 +: 8];
                        end
                    end
                end
            end
        end else if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // register bus: read side
        st_next.arready = s_axi_arvalid && !st_reg.arready &&
            !st_reg.rvalid;
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = `MDM_RESP_OK;
            case ({2'b00, s_axi_araddr[7:2]})
                `MDM_AX_STATUS >> 2: begin
                    st_next.rdata = {15'h0000, st_reg.last_hdr,
                        st_reg.mode};
                end
                `MDM_AX_MATCH >> 2: begin
                    st_next.rdata = {12'h000, st_reg.match};
                end
                `MDM_AX_COUNT >> 2: begin
                    st_next.rdata = {16'h0000, st_reg.xcnt};
                end
                default: begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = `MDM_RESP_ERR;
                end
            endcase
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign miso_o = st_reg.miso;
    assign miso_oe_o = st_reg.miso_oe;
    assign clock_output_oe_o = st_reg.clock_output_pin_oe;
    assign rx_on_o = st_reg.rx_on;
    assign tx_on_o = st_reg.tx_on;
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_off_float: assert property (
        st_reg.mode == MDM_OFF |=> !miso_oe_o && !clock_output_oe_o)
        else $error("outputs driven in off");
    a_rst_to_off: assert property (
        !modem_rst_n_i |=> st_reg.mode == MDM_OFF)
        else $error("reset did not force off");
    a_off_leave: assert property (
        st_reg.mode == MDM_OFF && modem_rst_n_i |=>
        st_reg.mode == MDM_WAKE && st_reg.cnt == 20'(T_OFF_CYC))
        else $error("off did not start wake");
    a_hib_cmd: assert property (
        st_reg.mode == MDM_IDLE && modem_rst_n_i && spi_ev.wr &&
        spi_ev.waddr == `MDM_R_MODE && spi_ev.wdata[`MDM_B_HIB]
        |=> st_reg.mode == MDM_HIB)
        else $error("hibernate command lost");
    a_hib_wake: assert property (
        st_reg.mode == MDM_HIB && attention_wake_i && modem_rst_n_i |=>
        st_reg.mode == MDM_WAKE && st_reg.cnt == 20'(T_HIB_CYC))
        else $error("hibernate wake wrong");
    a_doze_wake: assert property (
        st_reg.mode == MDM_DOZE && attention_wake_i && modem_rst_n_i
        |=> st_reg.cnt == 20'(T_DOZE_CYC) + {10'h000, $past(half), 1'b0})
        else $error("doze wake time wrong");
    a_rx_warm: assert property (
        $rose(st_reg.mode == MDM_RXW) |->
        st_reg.cnt == 20'(T_RXTX_CYC) ##1 st_reg.mode != MDM_RX)
        else $error("receive warmup wrong");
    a_port_dead: assert property (
        (st_reg.mode inside {MDM_HIB, MDM_DOZE})[*3] |-> !spi_ev.wr)
        else $error("serial write while asleep");
    a_clock_output_pin_gate: assert property (
        (st_reg.mode == MDM_DOZE && !ctl[`MDM_B_CLOCK_OUTPUT_PIN_DOZE])[*2] |->
        !clock_output_pin_o)
        else $error("clock out in doze");
    a_miso_float: assert property (
        (pins_i.ce_n && st_reg.mode == MDM_IDLE)[*2] |->
        miso_oe_o == !$past(ctl[`MDM_B_FLOAT]))
        else $error("idle miso drive wrong");

    c_rx_on: cover property (st_reg.mode == MDM_RX);
    c_doze_tmr: cover property (st_reg.mode == MDM_DOZE &&
        !attention_wake_i ##1 st_reg.mode == MDM_WAKE);
    c_spi_wr: cover property (spi_ev.wr);
    c_spi_rd: cover property (miso_oe_o && !pins_i.ce_n);
endmodule : mdm_top

// [mdm_top_bench.sv]
// self-checking bench for the modem command port top
`timescale 1ns/1ps
module mdm_top_bench;
    import mdm_pkg::*;
    localparam int T_OFF = 40;
    localparam int T_RX = 25;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic mrst_n = 1'b0;
    logic att = 1'b0;
    logic ren = 1'b0;
    logic tgl = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [15:0] w;
    logic miso, miso_oe, clock_output_pin, clock_output_pin_oe, rx_on, tx_on, miso_w;
    mdm_pins_t pins;
    int tg = 0, tg0, cyc = 0, failures = 0, tests_run = 0;
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) tgl <= ~tgl;
    always @(clock_output_pin) tg++;
    // undriven miso shows a changing pattern, not its last value
    assign miso_w = miso_oe ? miso : tgl;
    mdm_host i_host (.clk_i(clk_i), .miso_i(miso_w), .pins_o(pins));
    mdm_top #(.T_OFF_CYC(T_OFF), .T_HIB_CYC(30), .T_DOZE_CYC(20),
        .T_RXTX_CYC(T_RX)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .modem_rst_n_i(mrst_n), .pins_i(pins), .attention_wake_i(att),
        .radio_operation_enable_i(ren), .miso_o(miso), .miso_oe_o(miso_oe),
        .clock_output_pin_o(clock_output_pin), .clock_output_oe_o(clock_output_pin_oe),
        .rx_on_o(rx_on), .tx_on_o(tx_on), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] v,
                       output logic [1:0] resp);
        awaddr <= a;
        wdata <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk_i);
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] v,
                       output logic [1:0] resp);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready) arv <= 1'b0;
        end while (!rvalid);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk_i);
    endtask : axr
    task automatic mode_is(input logic [8:0] m);
        axr(8'h00, d, r);
        chk("mode", {23'h0, d[8:0]}, {23'h0, m});
    endtask : mode_is
    task automatic wait_mode(input logic [8:0] m);
        int n;
        n = 0;
        do begin
            axr(8'h00, d, r);
            n++;
        end while (d[8:0] !== m && n < 100);
        chk("mode", {23'h0, d[8:0]}, {23'h0, m});
    endtask : wait_mode
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        mode_is(MDM_OFF);
        chk("clock_output_pin_oe", {31'h0, clock_output_pin_oe}, 32'h0);
        axr(8'h0C, d, r);
        chk("unmapped", {30'h0, r}, 32'h2);
        axw(8'h00, 32'h1, r);
        chk("ro_write", {30'h0, r}, 32'h2);
        axw(8'h04, 32'h64, r);
        chk("match_wr", {30'h0, r}, 32'h0);
        axr(8'h04, d, r);
        chk("match", d, 32'h64);
        $display("end bus");
        mrst_n <= 1'b1;
        repeat (10) @(posedge clk_i);
        mode_is(MDM_WAKE);
        wait_mode(MDM_IDLE);
        chk("miso_oe", {31'h0, miso_oe}, 32'h0);
        i_host.txn(8'h07, 16'h0200, w);
        chk("miso_oe", {31'h0, miso_oe}, 32'h1);
        chk("miso_lo", {31'h0, miso}, 32'h0);
        i_host.txn(8'h0A, 16'h0004, w);
        i_host.txn(8'h87, 16'h0000, w);
        chk("rd07", {16'h0, w}, 32'h0200);
        axr(8'h00, d, r);
        chk("hdr", {24'h0, d[16:9]}, 32'h87);
        axr(8'h08, d, r);
        chk("count", d, 32'h3);
        $display("end serial");
        i_host.txn(8'h01, 16'h0006, w);
        mode_is(MDM_DOZE);
        tg0 = tg;
        repeat (60) @(posedge clk_i);
        chk("clock_output_pin_toggle", {31'h0, tg != tg0}, 32'h1);
        wait_mode(MDM_IDLE);
        i_host.txn(8'h01, 16'h0001, w);
        mode_is(MDM_HIB);
        i_host.txn(8'h07, 16'h0800, w);
        att <= 1'b1;
        wait_mode(MDM_IDLE);
        att <= 1'b0;
        i_host.txn(8'h87, 16'h0000, w);
        chk("hib_ignored", {16'h0, w}, 32'h0200);
        i_host.txn(8'h07, 16'h0000, w);
        i_host.txn(8'h01, 16'h0002, w);
        mode_is(MDM_DOZE);
        tg0 = tg;
        repeat (60) @(posedge clk_i);
        chk("clock_output_pin_gated", {31'h0, tg != tg0}, 32'h0);
        att <= 1'b1;
        wait_mode(MDM_IDLE);
        att <= 1'b0;
        $display("end low power");
        ren <= 1'b1;
        repeat (T_RX - 5) @(posedge clk_i);
        chk("rx_early", {31'h0, rx_on}, 32'h0);
        repeat (15) @(posedge clk_i);
        chk("rx_on", {31'h0, rx_on}, 32'h1);
        ren <= 1'b0;
        wait_mode(MDM_IDLE);
        i_host.txn(8'h01, 16'h0008, w);
        ren <= 1'b1;
        repeat (T_RX + 10) @(posedge clk_i);
        chk("tx_on", {31'h0, tx_on}, 32'h1);
        mrst_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        mode_is(MDM_OFF);
        chk("tx_off", {31'h0, tx_on}, 32'h0);
        chk("clock_output_pin_oe", {31'h0, clock_output_pin_oe}, 32'h0);
        $display("end radio");
        wrap_up();
    end
endmodule : mdm_top_bench
